//--- testbench/ueirq_phy_model.sv
// free-running phy clock seen by the vbus timers
// assumes the design synchronises it; kept slow against sys_clk
module ueirq_phy_model
(
  output logic phyTick
);
  timeunit 1ns;
  timeprecision 1ps;
  initial phyTick = 1'b0;
  // the phy clock runs free, so it does not stop between sessions
  always #57 phyTick = ~phyTick;
endmodule // ueirq_phy_model

//--- testbench/ueirq_regs_monitor.sv
// concurrent checks on the ports of ueirq_regs
// assumes one clock domain, reset active low
module ueirq_regs_monitor
#(
  parameter NEP = 16
)
(
  input logic           sys_clk,
  input logic           reset_n,
  input logic           psel,
  input logic           penable,
  input logic           pwrite,
  input logic           pready,
  input logic           pslverr,
  input logic [NEP-1:0] inEpIrq,
  input logic           inEpIrq_o,
  input logic           vbusPulseOn,
  input logic           vbusDischargeOn,
  input logic [8:0]     txThrWords,
  input logic           rxThrOn,
  input logic           isoTxThrOn,
  input logic           nonIsoTxThrOn,
  input logic           parkValid,
  input logic [NEP-1:0] parkEp
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  a_ready_one_wait: assert property (psel && penable && !pready |=> pready)
    else $error("no ready after access");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_in_irq_quiet: assert property ((inEpIrq == '0)[*3] |-> !inEpIrq_o)
    else $error("in irq without pending endpoint");
  a_vbus_exclusive: assert property (!(vbusPulseOn && vbusDischargeOn))
    else $error("pulse and discharge together");
  a_dis_after_pulse: assert property ($rose(vbusDischargeOn)
    |-> $past(vbusPulseOn) || $past(vbusPulseOn, 2))
    else $error("discharge without pulse");
  a_tx_by_write: assert property ($changed(txThrWords)
    |-> $past(psel && pwrite) || $past(psel && pwrite, 2))
    else $error("tx threshold moved without write");
  a_park_needs_thr: assert property (parkValid
    |-> rxThrOn || isoTxThrOn || nonIsoTxThrOn)
    else $error("park without thresholding");
  a_park_onehot: assert property (parkValid |-> $onehot(parkEp))
    else $error("park endpoint not one-hot");
  c_err: cover property (pslverr);
  c_dis: cover property ($rose(vbusDischargeOn));
  c_park: cover property (parkValid);
endmodule // ueirq_regs_monitor
bind ueirq_regs ueirq_regs_monitor #(.NEP(NEP)) u_mon (.sys_clk, .reset_n, .psel, .penable,
  .pwrite, .pready, .pslverr, .inEpIrq, .inEpIrq_o, .vbusPulseOn, .vbusDischargeOn,
  .txThrWords, .rxThrOn, .isoTxThrOn, .nonIsoTxThrOn, .parkValid, .parkEp);

//--- testbench/usb_device_ep_irq_threshold_regs_tb_top.sv
// self-checking bench for ueirq_regs over APB
// assumes the phy model supplies the phy clock
module usb_device_ep_irq_threshold_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int NEP = 4;
  logic sys_clk = 0, reset_n = 0, clkEn = 1, psel = 0, penable = 0, pwrite = 0;
  logic srpStartAsync = 0, pready, pslverr, rerr, outEpIrq, inEpIrq_o, phyTickAsync;
  logic vbusPulseOn, vbusDischargeOn, rxThrOn, isoTxThrOn, nonIsoTxThrOn, parkValid;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rdat, d, x = 32'h0000E41C;
  logic [NEP*32-1:0] outEpCauses = '0;
  logic [NEP-1:0] outEpIsControl = '0, inEpIrq = '0, inTokenEp = '0, parkEp;
  logic [8:0] rxThrWords, txThrWords;
  logic ctl;
  int err_count = 0, n_tests = 0, cyc = 0, ep, n;
  logic [11:0] ad [6] = '{12'h814, 12'h818, 12'h81C, 12'h828, 12'h82C, 12'h830};
  logic [31:0] rv [6] = '{32'h0, 32'h0, 32'h0, 32'h000017D7, 32'h000005B8, 32'h0};
  logic [31:0] wm [6] = '{32'h35B, 32'h0, 32'hFFFFFFFF, 32'hFFFF, 32'hFFF, 32'h0BFF07FF};
  int bl [7] = '{9, 8, 6, 4, 3, 1, 0};
  always #12.5 sys_clk = ~sys_clk;
  ueirq_phy_model u_ueirq_phy_model (.phyTick(phyTickAsync));
  ueirq_regs #(.NEP(NEP)) u_ueirq_regs (.sys_clk, .reset_n, .clkEn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .outEpCauses, .outEpIsControl, .inEpIrq,
    .inTokenEp, .phyTickAsync, .srpStartAsync, .outEpIrq, .inEpIrq_o, .vbusPulseOn,
    .vbusDischargeOn, .rxThrOn, .rxThrWords, .isoTxThrOn, .nonIsoTxThrOn, .txThrWords,
    .parkValid, .parkEp);
  function logic [31:0] rnd();
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  // setup-done, back-to-back setup and token-while-disabled count on control only
  function logic oexp(int b, logic c);
    return c || !(b == 6 || b == 4 || b == 3);
  endfunction
  task end_of_test;
    if (err_count == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e)
    begin
      err_count++;
      $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      err_count++;
      end_of_test;
    end
  end
  initial
  begin
    repeat (12) @(posedge sys_clk);
    reset_n <= 1'b1;
    for (int i = 0; i < 6; i++)
    begin
      apb(0, ad[i], 32'h0);
      chk(rdat, rv[i]);
    end
    repeat (4) for (int i = 0; i < 6; i++)
    begin
      d = rnd();
      apb(1, ad[i], d);
      apb(0, ad[i], 32'h0);
      chk(rdat, d & wm[i]);
    end
    apb(0, 12'h900, 32'h0);
    chk(rdat, 32'h0);
    chk(rerr, 1'b1);
    // lengths kept at eight words or more, as software must
    d = rnd() | 32'h08110023;
    apb(1, 12'h830, d);
    inTokenEp <= 4'h4;
    repeat (4) @(posedge sys_clk);
    chk({rxThrWords, txThrWords}, {d[25:17], d[10:2]});
    chk({rxThrOn, isoTxThrOn, nonIsoTxThrOn, parkValid, parkEp}, 8'hF4);
    apb(1, 12'h81C, 32'h0);
    foreach (bl[k])
    begin
      ep = rnd() % NEP;
      ctl = rnd() & 1;
      apb(1, 12'h814, 32'h1 << bl[k]);
      outEpIsControl <= ctl << ep;
      outEpCauses[ep*32+bl[k]] <= 1'b1;
      repeat (4) @(posedge sys_clk);
      apb(0, 12'h818, 32'h0);
      chk(rdat, oexp(bl[k], ctl) ? 32'h10000 << ep : 32'h0);
      chk(outEpIrq, 1'b0);
      apb(1, 12'h81C, 32'hFFFF0000);
      repeat (4) @(posedge sys_clk);
      chk(outEpIrq, oexp(bl[k], ctl));
      outEpCauses <= '0;
      apb(1, 12'h81C, 32'h0);
      repeat (4) @(posedge sys_clk);
      apb(0, 12'h818, 32'h0);
      chk(rdat, 32'h0);
    end
    inEpIrq <= 4'hA;
    outEpCauses[32] <= 1'b1;
    apb(1, 12'h814, 32'h1);
    apb(1, 12'h81C, 32'h0000FFFF);
    repeat (4) @(posedge sys_clk);
    apb(0, 12'h818, 32'h0);
    chk(rdat, 32'h0002000A);
    chk({inEpIrq_o, outEpIrq}, 2'b10);
    apb(1, 12'h82C, 32'h1);
    apb(1, 12'h828, 32'h1);
    srpStartAsync <= 1'b1;
    while (vbusPulseOn !== 1'b1) @(posedge sys_clk);
    n = 0;
    while (vbusPulseOn === 1'b1)
    begin
      @(posedge sys_clk);
      n++;
    end
    // 1024 phy ticks of 114 ns is about 4670 sys clocks
    chk(n > 4600 && n < 4740, 1'b1);
    repeat (2) @(posedge sys_clk);
    chk(vbusDischargeOn, 1'b1);
    end_of_test;
  end
endmodule // usb_device_ep_irq_threshold_regs_tb_top

//--- verilog/ueirq_defines.vh
// constants for the endpoint interrupt / threshold register group
// assumes inclusion by bare name from design files only
`ifndef UEIRQ_DEFINES_VH
`define UEIRQ_DEFINES_VH
// ************************************************************
// register byte offsets (low 12 bits of paddr)
// ************************************************************
`define UEIRQ_OFS_OUT_MASK     12'h814
`define UEIRQ_OFS_SUMMARY      12'h818
`define UEIRQ_OFS_SUM_MASK     12'h81C
`define UEIRQ_OFS_VBUS_DIS     12'h828
`define UEIRQ_OFS_VBUS_PULSE   12'h82C
`define UEIRQ_OFS_THR_CTL      12'h830
// ************************************************************
// reset values and writable bit maps
// ************************************************************
`define UEIRQ_RST_OUT_MASK     32'h00000000
`define UEIRQ_RST_SUM_MASK     32'h00000000
`define UEIRQ_RST_VBUS_DIS     16'h17D7
`define UEIRQ_RST_VBUS_PULSE   12'h5B8
`define UEIRQ_RST_THR_CTL      32'h00000000
`define UEIRQ_WMASK_OUT_MASK   32'h0000035B
`define UEIRQ_WMASK_THR_CTL    32'h0BFF07FF
// ************************************************************
// field positions
// ************************************************************
`define UEIRQ_BIT_BUF_NA       9
`define UEIRQ_BIT_PKT_ERR      8
`define UEIRQ_BIT_B2B_SETUP    6
`define UEIRQ_BIT_TOK_DIS      4
`define UEIRQ_BIT_SETUP_DONE   3
`define UEIRQ_BIT_EP_DIS       1
`define UEIRQ_BIT_XFER_DONE    0
`define UEIRQ_BIT_PARK         27
`define UEIRQ_RX_LEN_HI        25
`define UEIRQ_RX_LEN_LO        17
`define UEIRQ_BIT_RX_EN        16
`define UEIRQ_TX_LEN_HI        10
`define UEIRQ_TX_LEN_LO        2
`define UEIRQ_BIT_ISO_EN       1
`define UEIRQ_BIT_NISO_EN      0
// vbus counts are in units of this many phy clocks, as a shift
`define UEIRQ_VBUS_UNIT_SHIFT  10
`endif

//--- verilog/ueirq_out_gate.v
// gates one OUT endpoint's causes with the common OUT mask
// assumes causes are synchronous levels from the endpoint status logic
`include "ueirq_defines.vh"
module ueirq_out_gate
(
  input  wire [31:0] causes,
  input  wire [31:0] commonMask,
  input  wire        isControl,
  output wire        irqOut
);
  wire [31:0] eff;
  // control-only masks drop out for other endpoint types
  assign eff = commonMask & ~({32{~isControl}} &
               ((32'h1 << `UEIRQ_BIT_B2B_SETUP) | (32'h1 << `UEIRQ_BIT_TOK_DIS) |
                (32'h1 << `UEIRQ_BIT_SETUP_DONE)));
  assign irqOut = |(causes & eff);
endmodule // ueirq_out_gate

//--- verilog/ueirq_regs.v
// APB register group: endpoint interrupt masks, summary, vbus timing,
// fifo thresholds
// assumes per-endpoint cause vectors are sys_clk levels; phy tick and srp
// request come from another domain and are synchronised here
`include "ueirq_defines.vh"
module ueirq_regs
#(
  parameter NEP = 16
)
(
  input  wire             sys_clk,
  input  wire             reset_n,
  input  wire             clkEn,
  input  wire             psel,
  input  wire             penable,
  input  wire             pwrite,
  input  wire [11:0]      paddr,
  input  wire [31:0]      pwdata,
  output reg  [31:0]      prdata,
  output reg              pready,
  output reg              pslverr,
  input  wire [NEP*32-1:0] outEpCauses,
  input  wire [NEP-1:0]   outEpIsControl,
  input  wire [NEP-1:0]   inEpIrq,
  input  wire [NEP-1:0]   inTokenEp,
  input  wire             phyTickAsync,
  input  wire             srpStartAsync,
  output reg              outEpIrq,
  output reg              inEpIrq_o,
  output reg              vbusPulseOn,
  output reg              vbusDischargeOn,
  output reg              rxThrOn,
  output reg  [8:0]       rxThrWords,
  output reg              isoTxThrOn,
  output reg              nonIsoTxThrOn,
  output reg  [8:0]       txThrWords,
  output reg              parkValid,
  output reg  [NEP-1:0]   parkEp
);
  // ************************************************************
  // registers
  // ************************************************************
  reg  [31:0] outMask_r;
  reg  [31:0] sumMask_r;
  reg  [15:0] vbusDis_r;
  reg  [11:0] vbusPulse_r;
  reg  [31:0] thrCtl_r;
  reg  [31:0] summary_r;
  reg  [1:0]  tickSync_r;
  reg  [1:0]  srpSync_r;
  reg         tickPrev_r;
  reg         srpPrev_r;
  reg         pulseWasOn_r;
  wire [NEP-1:0] outGated;
  wire [31:0] summaryNxt;
  wire        phyTick;
  wire        srpStart;
  wire        pulseBusy;
  wire        disBusy;
  wire        pulseEnd;
  wire        thrAny;
  wire        wrEn;
  wire        rdEn;
  wire        hit;
  reg  [31:0] rdData;
  reg  [15:0] outPad;
  reg  [15:0] inPad;

  // ************************************************************
  // per-endpoint OUT gating
  // ************************************************************
  genvar g;
  generate
    for (g = 0; g < NEP; g = g + 1)
    begin : gOut
      ueirq_out_gate uGate
      (
        .causes     (outEpCauses[g*32 +: 32]),
        .commonMask (outMask_r),
        .isControl  (outEpIsControl[g]),
        .irqOut     (outGated[g])
      );
    end
  endgenerate

  // summary mirrors endpoint status; clearing happens at the source
  // padded per half: a zero-width replication is illegal when NEP is 16
  always @*
  begin
    outPad = 16'h0000;
    inPad  = 16'h0000;
    outPad[NEP-1:0] = outGated;
    inPad[NEP-1:0]  = inEpIrq;
  end
  assign summaryNxt = {outPad, inPad};

  // ************************************************************
  // cross-domain inputs
  // ************************************************************
  assign phyTick  = tickSync_r[1] & ~tickPrev_r;
  assign srpStart = srpSync_r[1] & ~srpPrev_r;
  assign pulseEnd = pulseWasOn_r & ~pulseBusy;

  ueirq_vbus_timer #(.W(12)) uPulse
  (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .clkEn   (clkEn),
    .start   (srpStart),
    .phyTick (phyTick),
    .units   (vbusPulse_r),
    .busy    (pulseBusy)
  );

  ueirq_vbus_timer #(.W(16)) uDis
  (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .clkEn   (clkEn),
    .start   (pulseEnd),
    .phyTick (phyTick),
    .units   (vbusDis_r),
    .busy    (disBusy)
  );

  // ************************************************************
  // APB decode
  // ************************************************************
  assign wrEn = psel & penable & pwrite & ~pready;
  assign rdEn = psel & penable & ~pwrite & ~pready;
  assign hit  = (paddr == `UEIRQ_OFS_OUT_MASK) || (paddr == `UEIRQ_OFS_SUMMARY) ||
                (paddr == `UEIRQ_OFS_SUM_MASK) || (paddr == `UEIRQ_OFS_VBUS_DIS) ||
                (paddr == `UEIRQ_OFS_VBUS_PULSE) || (paddr == `UEIRQ_OFS_THR_CTL);

  always @*
  begin
    if (paddr == `UEIRQ_OFS_OUT_MASK)
      rdData = outMask_r;
    else if (paddr == `UEIRQ_OFS_SUMMARY)
      rdData = summary_r;
    else if (paddr == `UEIRQ_OFS_SUM_MASK)
      rdData = sumMask_r;
    else if (paddr == `UEIRQ_OFS_VBUS_DIS)
      rdData = {16'h0000, vbusDis_r};
    else if (paddr == `UEIRQ_OFS_VBUS_PULSE)
      rdData = {20'h00000, vbusPulse_r};
    else if (paddr == `UEIRQ_OFS_THR_CTL)
      rdData = thrCtl_r;
    else
      rdData = 32'h00000000;
  end

  assign thrAny = thrCtl_r[`UEIRQ_BIT_ISO_EN] | thrCtl_r[`UEIRQ_BIT_NISO_EN];

  // ************************************************************
  // clocked state
  // ************************************************************
  always @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      outMask_r       <= `UEIRQ_RST_OUT_MASK;
      sumMask_r       <= `UEIRQ_RST_SUM_MASK;
      vbusDis_r       <= `UEIRQ_RST_VBUS_DIS;
      vbusPulse_r     <= `UEIRQ_RST_VBUS_PULSE;
      thrCtl_r        <= `UEIRQ_RST_THR_CTL;
      summary_r       <= 32'h00000000;
      tickSync_r      <= 2'b00;
      srpSync_r       <= 2'b00;
      tickPrev_r      <= 1'b0;
      srpPrev_r       <= 1'b0;
      pulseWasOn_r    <= 1'b0;
      prdata          <= 32'h00000000;
      pready          <= 1'b0;
      pslverr         <= 1'b0;
      outEpIrq        <= 1'b0;
      inEpIrq_o       <= 1'b0;
      vbusPulseOn     <= 1'b0;
      vbusDischargeOn <= 1'b0;
      rxThrOn         <= 1'b0;
      rxThrWords      <= 9'h000;
      isoTxThrOn      <= 1'b0;
      nonIsoTxThrOn   <= 1'b0;
      txThrWords      <= 9'h000;
      parkValid       <= 1'b0;
      parkEp          <= {NEP{1'b0}};
    end
    else if (clkEn)
    begin
      tickSync_r   <= {tickSync_r[0], phyTickAsync};
      srpSync_r    <= {srpSync_r[0], srpStartAsync};
      tickPrev_r   <= tickSync_r[1];
      srpPrev_r    <= srpSync_r[1];
      pulseWasOn_r <= pulseBusy;
      summary_r    <= summaryNxt;
      // one wait state: answer in the cycle after the access phase begins
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~hit;
      if (rdEn)
        prdata <= hit ? rdData : 32'h00000000;
      if (wrEn)
      begin
        if (paddr == `UEIRQ_OFS_OUT_MASK)
          outMask_r <= pwdata & `UEIRQ_WMASK_OUT_MASK;
        else if (paddr == `UEIRQ_OFS_SUM_MASK)
          sumMask_r <= pwdata;
        else if (paddr == `UEIRQ_OFS_VBUS_DIS)
          vbusDis_r <= pwdata[15:0];
        else if (paddr == `UEIRQ_OFS_VBUS_PULSE)
          vbusPulse_r <= pwdata[11:0];
        else if (paddr == `UEIRQ_OFS_THR_CTL)
          thrCtl_r <= pwdata & `UEIRQ_WMASK_THR_CTL;
      end
      // summary mask gates only the core interrupt lines
      outEpIrq  <= |(summary_r[31:16] & sumMask_r[31:16]);
      inEpIrq_o <= |(summary_r[15:0] & sumMask_r[15:0]);
      vbusPulseOn     <= pulseBusy;
      vbusDischargeOn <= disBusy;
      rxThrOn    <= thrCtl_r[`UEIRQ_BIT_RX_EN];
      rxThrWords <= thrCtl_r[`UEIRQ_RX_LEN_HI:`UEIRQ_RX_LEN_LO];
      isoTxThrOn    <= thrCtl_r[`UEIRQ_BIT_ISO_EN];
      nonIsoTxThrOn <= thrCtl_r[`UEIRQ_BIT_NISO_EN];
      txThrWords <= thrCtl_r[`UEIRQ_TX_LEN_HI:`UEIRQ_TX_LEN_LO];
      // parking only means something while transmit thresholding runs
      parkValid <= thrAny & thrCtl_r[`UEIRQ_BIT_PARK] & (|inTokenEp);
      parkEp    <= (thrAny & thrCtl_r[`UEIRQ_BIT_PARK]) ? inTokenEp : {NEP{1'b0}};
    end
  end
endmodule // ueirq_regs

//--- verilog/ueirq_vbus_timer.v
// timer counting a programmed value in units of 1024 phy clocks
// assumes start is a one-cycle pulse on sys_clk; phy tick is a synchronised pulse
`include "ueirq_defines.vh"
module ueirq_vbus_timer
#(
  parameter W = 16
)
(
  input  wire         sys_clk,
  input  wire         reset_n,
  input  wire         clkEn,
  input  wire         start,
  input  wire         phyTick,
  input  wire [W-1:0] units,
  output reg          busy
);
  reg [W+`UEIRQ_VBUS_UNIT_SHIFT-1:0] cnt_r;
  always @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cnt_r <= {(W+`UEIRQ_VBUS_UNIT_SHIFT){1'b0}};
      busy  <= 1'b0;
    end
    else if (clkEn)
    begin
      if (start)
      begin
        cnt_r <= {units, {`UEIRQ_VBUS_UNIT_SHIFT{1'b0}}};
        busy  <= |units;
      end
      else if (busy && phyTick)
      begin
        cnt_r <= cnt_r - {{(W+`UEIRQ_VBUS_UNIT_SHIFT-1){1'b0}}, 1'b1};
        busy  <= (cnt_r != {{(W+`UEIRQ_VBUS_UNIT_SHIFT-1){1'b0}}, 1'b1});
      end
    end
  end
endmodule // ueirq_vbus_timer
